// ==== flb_ctrl.v ====
// Purpose: Flash boot-mode latch, address map and program/erase sequencer.
// Assumes: Protection bits come from a software-written register elsewhere.
// Notes: Long operation times are parameters so simulation can shorten them.
`timescale 1ns/1ps
`include "flb_map.vh"
module flb_ctrl #(
  parameter FLASH_128K = 1,
  parameter [31:0] PROG_CYC = (`FLB_PROG_NS * 1000 + `FLB_CLK_PS - 1) / `FLB_CLK_PS,
  parameter [31:0] BLKER_CYC = (`FLB_BLKER_NS / `FLB_CLK_PS) * 1000,
  parameter [31:0] CHIPER_CYC = (`FLB_CHIPER_NS / `FLB_CLK_PS) * 1000
) (
  input wire ref_clk, // System clock.
  input wire rstn, // Asynchronous reset, active low.
  input wire bootPin, // Startup source level.
  output wire singleChip, // High in single chip mode.
  output wire modeValid, // Boot mode has been latched.
  input wire busReq, // Bus address valid.
  input wire [31:0] busAddr, // Bus byte address.
  output reg mapValid_r, // Decode result valid.
  output reg mapFlash_r, // Address hits flash.
  output reg mapRom_r, // Address hits boot ROM.
  output reg mapMiss_r, // Address hits neither.
  output reg [`FLB_OFF_W-1:0] mapOff_r, // Offset within flash or ROM.
  input wire [3:0] protBlk, // Per-block inhibit from software.
  output wire bufReady, // Page buffer accepts a word.
  input wire bufValid, // Page buffer word strobe.
  input wire [`FLB_IDX_W-1:0] bufIdx, // Page buffer word index.
  input wire [31:0] bufData, // Page buffer word.
  output wire cmdReady, // Sequencer accepts a command.
  input wire cmdValid, // Command strobe.
  input wire [1:0] cmdOp, // Program, block erase or chip erase.
  input wire [31:0] cmdAddr, // Target byte address.
  output wire busy, // Operation in progress.
  output reg done_r, // Operation finished, one cycle.
  output reg refused_r, // Command refused, one cycle.
  output reg arrWe_r, // Array word write strobe.
  output reg [`FLB_OFF_W-1:0] arrAddr_r, // Array byte offset.
  output reg [31:0] arrData_r, // Array word.
  output reg arrBlkErase_r, // Array block erase start.
  output reg arrChipErase_r, // Array chip erase start.
  output reg [1:0] arrBlk_r // Block being erased.
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_LOAD = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_DONE = 3'h3;
  localparam [2:0] ST_LAST = 3'h4;
  localparam [3:0] BLK_MASK = FLASH_128K ? 4'hf : 4'h3;

  // ************************************************************
  // Address map helpers
  // ************************************************************
  function [31:0] chipTop;
    input dummy;
    begin
      chipTop = FLASH_128K ? `FLB_CHIP_TOP_128 : `FLB_CHIP_TOP_64;
    end
  endfunction

  function [31:0] bootTop;
    input dummy;
    begin
      bootTop = FLASH_128K ? `FLB_BOOT_TOP_128 : `FLB_BOOT_TOP_64;
    end
  endfunction

  function [1:0] blockOf;
    input [31:0] off;
    begin
      blockOf = off[`FLB_BLOCK_LSB+1:`FLB_BLOCK_LSB];
    end
  endfunction

  // ************************************************************
  // Boot mode latch
  // ************************************************************
  reg latched_r;
  reg chipMode_r;

  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      latched_r <= 1'b0;
      chipMode_r <= 1'b0;
    end
    else if (!latched_r)
    begin
      latched_r <= 1'b1;
      chipMode_r <= bootPin;
    end
  end

  assign singleChip = chipMode_r;
  assign modeValid = latched_r;

  // ************************************************************
  // Address decode
  // ************************************************************
  reg hitFlash;
  reg hitRom;
  reg [31:0] offAll;

  always @*
  begin
    hitFlash = 1'b0;
    hitRom = 1'b0;
    offAll = busAddr;
    if (chipMode_r)
    begin
      hitFlash = busAddr <= chipTop(1'b0);
    end
    else
    begin
      offAll = busAddr - `FLB_BOOT_BASE;
      hitFlash = (busAddr >= `FLB_BOOT_BASE) && (busAddr <= bootTop(1'b0));
      hitRom = busAddr <= `FLB_ROM_TOP;
      if (hitRom)
      begin
        offAll = busAddr;
      end
    end
  end

  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mapValid_r <= 1'b0;
      mapFlash_r <= 1'b0;
      mapRom_r <= 1'b0;
      mapMiss_r <= 1'b0;
      mapOff_r <= {`FLB_OFF_W{1'b0}};
    end
    else
    begin
      mapValid_r <= busReq && latched_r;
      mapFlash_r <= busReq && latched_r && hitFlash;
      mapRom_r <= busReq && latched_r && hitRom;
      mapMiss_r <= busReq && latched_r && !hitFlash && !hitRom;
      mapOff_r <= offAll[`FLB_OFF_W-1:0];
    end
  end

  // ************************************************************
  // Program and erase sequencer
  // ************************************************************
  reg [2:0] state_r;
  reg [`FLB_IDX_W-1:0] idx_r;
  reg [`FLB_TMR_W-1:0] timer_r;
  reg [31:0] pageBase_r;
  wire [31:0] bufWord;
  wire [31:0] cmdOff;
  wire [1:0] cmdBlk;
  wire inRange;
  wire blkProt;
  wire anyProt;
  wire accept;
  wire refuse;

  assign cmdOff = chipMode_r ? cmdAddr : cmdAddr - `FLB_BOOT_BASE;
  assign cmdBlk = blockOf(cmdOff);
  assign inRange = chipMode_r ? (cmdAddr <= chipTop(1'b0))
                              : ((cmdAddr >= `FLB_BOOT_BASE) && (cmdAddr <= bootTop(1'b0)));
  assign blkProt = protBlk[cmdBlk];
  assign anyProt = |(protBlk & BLK_MASK);
  assign cmdReady = (state_r == ST_IDLE) && latched_r;
  assign accept = cmdValid && cmdReady;
  assign refuse = accept && (cmdOp == `FLB_OP_CHIPER ? anyProt
                                                     : (!inRange || blkProt || cmdOp > `FLB_OP_CHIPER));
  assign busy = state_r != ST_IDLE;
  assign bufReady = !busy;

  flb_page_buf uBuf (
    .ref_clk(ref_clk),
    .wrEn(bufValid && bufReady),
    .wrIdx(bufIdx),
    .wrData(bufData),
    .rdIdx(idx_r),
    .rdData(bufWord)
  );

  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= ST_IDLE;
      idx_r <= {`FLB_IDX_W{1'b0}};
      timer_r <= {`FLB_TMR_W{1'b0}};
      pageBase_r <= 32'h0000_0000;
      done_r <= 1'b0;
      refused_r <= 1'b0;
      arrWe_r <= 1'b0;
      arrAddr_r <= {`FLB_OFF_W{1'b0}};
      arrData_r <= 32'h0000_0000;
      arrBlkErase_r <= 1'b0;
      arrChipErase_r <= 1'b0;
      arrBlk_r <= 2'h0;
    end
    else
    begin
      done_r <= 1'b0;
      refused_r <= 1'b0;
      arrWe_r <= 1'b0;
      arrBlkErase_r <= 1'b0;
      arrChipErase_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          idx_r <= {`FLB_IDX_W{1'b0}};
          if (refuse)
          begin
            refused_r <= 1'b1;
          end
          else if (accept)
          begin
            case (cmdOp)
              `FLB_OP_PROG:
              begin
                pageBase_r <= {cmdOff[31:`FLB_PAGE_LSB], {`FLB_PAGE_LSB{1'b0}}};
                state_r <= ST_LOAD;
              end
              `FLB_OP_BLKER:
              begin
                arrBlkErase_r <= 1'b1;
                arrBlk_r <= cmdBlk;
                timer_r <= BLKER_CYC[`FLB_TMR_W-1:0];
                state_r <= ST_WAIT;
              end
              default:
              begin
                arrChipErase_r <= 1'b1;
                timer_r <= CHIPER_CYC[`FLB_TMR_W-1:0];
                state_r <= ST_WAIT;
              end
            endcase
          end
        end
        ST_LOAD:
        begin
          idx_r <= idx_r + 1'b1;
          if (idx_r == `FLB_WORDS - 1)
          begin
            state_r <= ST_LAST;
          end
          if (idx_r != {`FLB_IDX_W{1'b0}})
          begin
            arrWe_r <= 1'b1;
            arrData_r <= bufWord;
            arrAddr_r <= pageBase_r[`FLB_OFF_W-1:0] + {idx_r - 1'b1, 2'h0};
          end
        end
        ST_LAST:
        begin
          arrWe_r <= 1'b1;
          arrData_r <= bufWord;
          arrAddr_r <= pageBase_r[`FLB_OFF_W-1:0] | (`FLB_PAGE_LAST & {{`FLB_IDX_W{1'b1}}, 2'h0});
          timer_r <= PROG_CYC[`FLB_TMR_W-1:0];
          state_r <= ST_WAIT;
        end
        ST_WAIT:
        begin
          // No abort path exists once the array is busy.
          timer_r <= timer_r - 1'b1;
          if (timer_r <= {{(`FLB_TMR_W-1){1'b0}}, 1'b1})
          begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          done_r <= 1'b1;
          state_r <= ST_IDLE;
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== flb_map.vh ====
// Purpose: Constants for the flash layout, boot map and operation sequencer.
// Assumes: ref_clk at 250 MHz; bus addresses are byte addresses.
// Function
// - A page is all addresses sharing bits [31:7]; low bits run 0 to 0x7F.
// - A page holds 32 words of 32 bits; programming writes one whole page.
// - Flash is split into 32KB blocks: four for 128KB, two for 64KB.
// - Page program takes typically 1.25 ms, excluding data transfer.
// - Block erase erases exactly one block, typically 0.1 s.
// - Chip erase erases the whole array, typically 0.2 s.
// - Boot pin sampled at reset release: high single chip, low single boot.
// - Single boot maps flash from 0x3F80_0000 up to size-dependent limit.
// - Single boot maps boot ROM at the bottom, ending at 0x0000_0FFF.
// - Single chip maps flash from zero up to size-dependent limit.
// - Single chip fetches startup code from flash after reset.
// - Single boot ROM code reprograms flash over a serial port.
// - Program and erase can be inhibited per block by a protection setting.
// - Protection is a software setting only, no hardware pin path.
// - An erase in progress cannot be suspended or resumed.
`ifndef FLB_MAP_VH
`define FLB_MAP_VH
`define FLB_PAGE_LSB 7
`define FLB_PAGE_LAST 7'h7f
`define FLB_WORDS 32
`define FLB_IDX_W 5
`define FLB_BLOCK_LSB 15
`define FLB_OFF_W 17
`define FLB_CHIP_TOP_128 32'h0001_ffff
`define FLB_CHIP_TOP_64 32'h0000_ffff
`define FLB_BOOT_BASE 32'h3f80_0000
`define FLB_BOOT_TOP_128 32'h3f81_ffff
`define FLB_BOOT_TOP_64 32'h3f80_ffff
`define FLB_ROM_TOP 32'h0000_0fff
`define FLB_CLK_PS 4000
`define FLB_PROG_NS 1250000
`define FLB_BLKER_NS 100000000
`define FLB_CHIPER_NS 200000000
`define FLB_TMR_W 26
`define FLB_OP_PROG 2'h0
`define FLB_OP_BLKER 2'h1
`define FLB_OP_CHIPER 2'h2
`endif

// ==== flb_page_buf.v ====
// Purpose: Page buffer holding one page of words before programming.
// Assumes: Single clock, one write and one read port.
// Notes: Read data come from a register one cycle after the address.
`timescale 1ns/1ps
`include "flb_map.vh"
module flb_page_buf (
  input wire ref_clk, // System clock.
  input wire wrEn, // Write strobe.
  input wire [`FLB_IDX_W-1:0] wrIdx, // Write word index.
  input wire [31:0] wrData, // Write word.
  input wire [`FLB_IDX_W-1:0] rdIdx, // Read word index.
  output reg [31:0] rdData // Registered read word.
);
  reg [31:0] mem [0:`FLB_WORDS-1];

  always @(posedge ref_clk)
  begin
    if (wrEn)
    begin
      mem[wrIdx] <= wrData;
    end
    rdData <= mem[rdIdx];
  end
endmodule

// ==== flb_arr_model.sv ====
// Purpose: Far-side model that records array traffic from the sequencer.
// Assumes: Strobes are one-cycle registers of the sequencer.
// Notes: Counts only grow; the bench compares running totals.
`timescale 1ns/1ps
module flb_arr_model (
  input wire ref_clk, // Clock.
  input wire arrWe_r, arrBlkErase_r, arrChipErase_r, // Array strobes.
  input wire [16:0] arrAddr_r, // Array offset.
  input wire [31:0] arrData_r, // Array word.
  input wire [1:0] arrBlk_r, // Erased block.
  output integer weCount = 0, blkCount = 0, chipCount = 0, // Event counts.
  output logic [16:0] firstAddr, lastAddr, // Written span.
  output logic [31:0] lastData, // Last word.
  output logic [1:0] lastBlk // Last erased block.
);
  always @(posedge ref_clk)
  begin
    if (arrWe_r)
    begin
      if (weCount == 0) firstAddr <= arrAddr_r;
      lastAddr <= arrAddr_r;
      lastData <= arrData_r;
      weCount <= weCount + 1;
    end
    if (arrBlkErase_r)
    begin
      blkCount <= blkCount + 1;
      lastBlk <= arrBlk_r;
    end
    if (arrChipErase_r) chipCount <= chipCount + 1;
  end
endmodule

// ==== flb_ctrl_chk.sv ====
// Purpose: Port checker for the boot map and sequencer.
// Assumes: Erase times shortened by the same parameters as the design.
// Notes: Bound to every flb_ctrl instance.
`timescale 1ns/1ps
module flb_ctrl_chk #(
  parameter FLASH_128K = 1,
  parameter int BLKER_CYC = 40,
  parameter int CHIPER_CYC = 60
) (
  input wire ref_clk, rstn, singleChip, modeValid, busReq, bootPin, // Clock, reset, mode.
  input wire [31:0] busAddr, // Bus address.
  input wire mapValid_r, mapFlash_r, mapRom_r, mapMiss_r, // Decode result.
  input wire [16:0] mapOff_r, // Offset.
  input wire [3:0] protBlk, // Protection.
  input wire cmdValid, cmdReady, busy, done_r, refused_r, arrWe_r, arrBlkErase_r, arrChipErase_r, // Sequencer.
  input wire [1:0] cmdOp // Command.
);
  localparam int BLK_HI = BLKER_CYC + 2;
  localparam int CHIP_HI = CHIPER_CYC + 2;
  wire [31:0] top = FLASH_128K ? 32'h0001_ffff : 32'h0000_ffff;
  wire [3:0] usedProt = FLASH_128K ? protBlk : {2'h0, protBlk[1:0]};
  wire inBoot = busAddr >= 32'h3f80_0000 && busAddr <= 32'h3f80_0000 + top;
  wire reqOk = busReq && modeValid;
  reg [5:0] weCnt_r;
  reg progOp_r;
  // Counts array writes of the command in flight.
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      weCnt_r <= 6'h00;
      progOp_r <= 1'b0;
    end
    else if (cmdValid && cmdReady)
    begin
      weCnt_r <= 6'h00;
      progOp_r <= cmdOp == 2'h0;
    end
    else if (arrWe_r)
      weCnt_r <= weCnt_r + 6'h01;
  end
  mode_latch_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(modeValid) |-> singleChip == $past(bootPin)) else $error("boot mode differs from pin");
  mode_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    modeValid && $past(modeValid) |-> $stable(singleChip)) else $error("boot mode changed");
  chip_flash_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    reqOk && singleChip && busAddr <= top |=> mapValid_r && mapFlash_r && mapOff_r == $past(busAddr[16:0]))
    else $error("chip mode flash decode wrong");
  chip_miss_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    reqOk && singleChip && busAddr > top |=> mapValid_r && mapMiss_r) else $error("chip mode miss wrong");
  boot_flash_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    reqOk && !singleChip && inBoot |=> mapFlash_r && mapOff_r == $past(busAddr[16:0]))
    else $error("boot mode flash decode wrong");
  boot_rom_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    reqOk && !singleChip && busAddr <= 32'h0000_0fff |=> mapRom_r && mapOff_r == $past(busAddr[16:0]))
    else $error("boot rom decode wrong");
  blk_time_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    arrBlkErase_r |-> ##[BLKER_CYC:BLK_HI] done_r) else $error("block erase time wrong");
  chip_time_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    arrChipErase_r |-> ##[CHIPER_CYC:CHIP_HI] done_r) else $error("chip erase time wrong");
  prot_chip_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmdValid && cmdReady && cmdOp == 2'h2 && usedProt != 4'h0 |=> refused_r && !arrChipErase_r)
    else $error("protected chip erase accepted");
  page_words_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    done_r && progOp_r |-> weCnt_r == 6'h20) else $error("page write count wrong");
  no_suspend_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    busy && !done_r |=> busy || done_r) else $error("operation stopped early");
endmodule
bind flb_ctrl flb_ctrl_chk #(.FLASH_128K(FLASH_128K), .BLKER_CYC(BLKER_CYC), .CHIPER_CYC(CHIPER_CYC)) flb_ctrl_chk_i (
  .ref_clk, .rstn, .singleChip, .modeValid, .busReq, .bootPin, .busAddr, .mapValid_r, .mapFlash_r, .mapRom_r,
  .mapMiss_r, .mapOff_r, .protBlk, .cmdValid, .cmdReady, .busy, .done_r, .refused_r, .arrWe_r, .arrBlkErase_r,
  .arrChipErase_r, .cmdOp);

// ==== tb_flb_ctrl.sv ====
// Purpose: Self-checking bench for the boot map and sequencer.
// Assumes: Times shortened to 20, 40 and 60 cycles.
// Notes: Map cases but one and refused commands are table rows; accepted commands are hand-written.
`timescale 1ns/1ps
module tb_flb_ctrl;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0, bootPin = 1'b1, busReq = 1'b0, bufValid = 1'b0, cmdValid = 1'b0;
  logic [31:0] busAddr = 32'h0, bufData = 32'h0, cmdAddr = 32'h0;
  logic [4:0] bufIdx = 5'h00;
  logic [3:0] protBlk = 4'h0;
  logic [1:0] cmdOp = 2'h0;
  wire singleChip, modeValid, mapValid_r, mapFlash_r, mapRom_r, mapMiss_r, bufReady, cmdReady, busy;
  wire done_r, refused_r, arrWe_r, arrBlkErase_r, arrChipErase_r;
  wire [16:0] mapOff_r, arrAddr_r, firstAddr, lastAddr;
  wire [31:0] arrData_r, lastData;
  wire [1:0] arrBlk_r, lastBlk;
  integer weCount, blkCount, chipCount, errCount = 0, compares = 0, i, n;
  // Rows: boot pin, address, {flash, rom, miss}, offset.
  logic [52:0] rows [0:9] = '{
    {1'b1, 32'h0000_0000, 3'h4, 17'h0}, {1'b1, 32'h0001_ffff, 3'h4, 17'h1ffff},
    {1'b1, 32'h0002_0000, 3'h1, 17'h0}, {1'b1, 32'h3f80_0000, 3'h1, 17'h0},
    {1'b0, 32'h0000_0000, 3'h2, 17'h0}, {1'b0, 32'h0000_0fff, 3'h2, 17'hfff},
    {1'b0, 32'h0000_1000, 3'h1, 17'h0}, {1'b0, 32'h3f80_0000, 3'h4, 17'h0},
    {1'b0, 32'h3f81_ffff, 3'h4, 17'h1ffff}, {1'b0, 32'h3f82_0000, 3'h1, 17'h0}};
  // Refused commands: protection, op, address.
  logic [37:0] refs [0:3] = '{{4'h4, 2'h1, 32'h0001_0000}, {4'h8, 2'h2, 32'h0}, {4'h0, 2'h1, 32'h0002_0000},
    {4'h0, 2'h3, 32'h0}};
  flb_ctrl #(.FLASH_128K(1), .PROG_CYC(20), .BLKER_CYC(40), .CHIPER_CYC(60)) flb_ctrl_i (
    .ref_clk, .rstn, .bootPin, .singleChip, .modeValid, .busReq, .busAddr, .mapValid_r, .mapFlash_r, .mapRom_r,
    .mapMiss_r, .mapOff_r, .protBlk, .bufReady, .bufValid, .bufIdx, .bufData, .cmdReady, .cmdValid, .cmdOp,
    .cmdAddr, .busy, .done_r, .refused_r, .arrWe_r, .arrAddr_r, .arrData_r, .arrBlkErase_r, .arrChipErase_r, .arrBlk_r);
  flb_arr_model flb_arr_model_i (.ref_clk, .arrWe_r, .arrBlkErase_r, .arrChipErase_r, .arrAddr_r, .arrData_r,
    .arrBlk_r, .weCount, .blkCount, .chipCount, .firstAddr, .lastAddr, .lastData, .lastBlk);
  initial forever #2 ref_clk = ~ref_clk;
  task cyc;
  begin
    @(posedge ref_clk);
    #1;
  end
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      errCount = errCount + 1;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  end
  endtask
  task do_reset(input logic pin);
  begin
    rstn = 1'b0;
    bootPin = pin;
    repeat (6) cyc;
    chk("reset ready", 32'h2, {30'h0, bufReady, cmdReady});
    rstn = 1'b1;
    repeat (2) cyc;
  end
  endtask
  task map(input logic [31:0] a, input logic [2:0] kind, input logic [16:0] off);
  begin
    busReq = 1'b1;
    busAddr = a;
    cyc;
    busReq = 1'b0;
    chk("map kind", {29'h1, kind}, {28'h0, mapValid_r, mapFlash_r, mapRom_r, mapMiss_r});
    if (kind != 3'h1) chk("map offset", {15'h0, off}, {15'h0, mapOff_r});
    cyc;
    chk("map pulse", 32'h0, {31'h0, mapValid_r});
  end
  endtask
  task cmd(input logic [1:0] op, input logic [31:0] a);
  begin
    // An idle edge keeps a new strobe apart from the previous release.
    cyc;
    cmdValid = 1'b1;
    cmdOp = op;
    cmdAddr = a;
    cyc;
    cmdValid = 1'b0;
    n = 0;
    // A refusal pulse stands only in the cycle right after the strobe.
    while (done_r !== 1'b1 && refused_r !== 1'b1 && n < 300)
    begin
      cyc;
      n = n + 1;
    end
  end
  endtask
  task finishTest;
  begin
    $display("compares %0d errCount %0d", compares, errCount);
    if (errCount == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  initial
  begin
    #20000;
    errCount = errCount + 1;
    finishTest;
  end
  initial
  begin
    for (i = 0; i < 10; i = i + 1)
    begin
      if (i == 0 || i == 4) do_reset(rows[i][52]);
      map(rows[i][51:20], rows[i][19:17], rows[i][16:0]);
    end
    bootPin = 1'b1;
    cyc;
    map(32'h0000_0010, 3'h2, 17'h10);
    do_reset(1'b1);
    for (i = 0; i < 32; i = i + 1)
    begin
      bufValid = 1'b1;
      bufIdx = i[4:0];
      bufData = 32'ha5a5_0000 + i;
      cyc;
    end
    bufValid = 1'b0;
    cmd(2'h0, 32'h0000_0184);
    chk("program cycles", 32'h1, {31'h0, n >= 53 && n <= 57});
    chk("page words", 32'd32, weCount);
    chk("page first", 32'h180, {15'h0, firstAddr});
    chk("page last", 32'h1fc, {15'h0, lastAddr});
    chk("page data", 32'ha5a5_001f, lastData);
    cyc;
    chk("busy after done", 32'h0, {31'h0, busy});
    for (i = 0; i < 4; i = i + 1)
    begin
      protBlk = refs[i][37:34];
      cmd(refs[i][33:32], refs[i][31:0]);
      chk("refused", 32'h1, {31'h0, refused_r});
    end
    chk("refused erases", 32'h0, blkCount + chipCount);
    protBlk = 4'h4;
    cmd(2'h1, 32'h0000_8000);
    chk("block erase cycles", 32'd41, n);
    chk("erased block", 32'h1, {30'h0, lastBlk});
    protBlk = 4'h0;
    cmd(2'h2, 32'h0);
    chk("chip erase cycles", 32'd61, n);
    chk("chip erases", 32'h1, chipCount);
    finishTest;
  end
endmodule
